// ==== src/swd_watchdog.sv ====
`timescale 1ns/1ps

module swd_watchdog
  import swd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire swd_sw_req_t sw_req,
  input wire logic idle_mode,
  input wire logic power_down_mode,
  output logic wdt_reset_out,
  output logic watchdog_reset_status_flag,
  output logic watchdog_running,
  output logic [SWD_REG_W-1:0] watchdog_reload_register,
  output logic [SWD_CNT_W-1:0] count_value
);

  logic [SWD_CNT_W-1:0] count_reg, count_next;
  logic [SWD_REG_W-1:0] reload_reg, reload_next;
  logic running_reg, running_next;
  logic pending_reg, pending_next;
  logic status_reg, status_next;
  logic rst_out_reg, rst_out_next;
  logic halt;
  logic tick;
  logic reload_do;
  logic overflow;

  assign halt = idle_mode | power_down_mode;

  // Count rate comes from the select bit of the reload register
  swd_prescaler #(
    .FAST_DIV(SWD_FAST_DIV),
    .SLOW_FACTOR(SWD_SLOW_FACTOR)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .halt(halt),
    .slow_sel(reload_reg[SWD_PSEL_BIT]),
    .tick(tick)
  );

  // Refresh sequencing: one request pulse per instruction
  always_comb begin
    pending_next = pending_reg;
    reload_do = 1'b0;
    if (sw_req.valid) begin
      // Any instruction after the refresh one ends the pending window unless it sets the refresh bit again
      reload_do = pending_reg && sw_req.watchdog_start_bit && running_reg;
      pending_next = sw_req.watchdog_refresh_bit;
    end
  end

  // Reload register, start bit, counter and overflow
  always_comb begin
    reload_next = reload_reg;
    running_next = running_reg;
    count_next = count_reg;
    status_next = status_reg;
    rst_out_next = 1'b0;
    overflow = running_reg && tick && !halt && (count_reg == SWD_CNT_TOP);
    if (sw_req.valid && sw_req.reload_wr) begin
      reload_next = sw_req.reload_data;
    end
    // A cleared start bit never stops a running timer
    if (sw_req.valid && sw_req.watchdog_start_bit) begin
      running_next = 1'b1;
    end
    if (reload_do) begin
      // Low byte restarts from zero; it has no load path of its own
      count_next = {reload_reg[SWD_REL_W-1:0], SWD_LOW_ZERO};
    end else if (overflow) begin
      // The internal reset it raises clears the counter and the run bit; the reload register keeps its value
      count_next = SWD_CNT_RST;
      running_next = 1'b0;
      rst_out_next = 1'b1;
      status_next = 1'b1;
    end else if (running_reg && tick && !halt) begin
      count_next = count_reg + 1'b1;
    end
  end

  // Only the external reset clears the cause flag, so it outlives the pulse
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_reg <= SWD_CNT_RST;
      reload_reg <= SWD_RELOAD_RST;
      running_reg <= 1'b0;
      pending_reg <= 1'b0;
      status_reg <= 1'b0;
      rst_out_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      reload_reg <= reload_next;
      running_reg <= running_next;
      pending_reg <= pending_next;
      status_reg <= status_next;
      rst_out_reg <= rst_out_next;
    end
  end

  assign wdt_reset_out = rst_out_reg;
  assign watchdog_reset_status_flag = status_reg;
  assign watchdog_running = running_reg;
  assign watchdog_reload_register = reload_reg;
  assign count_value = count_reg;

  // Helper: cycles between ticks, valid only over an undisturbed period
  logic [$clog2(SWD_SLOW_DIV)+1:0] gap_reg, gap_next;
  logic gap_ok_reg, gap_ok_next;
  logic sel_d_reg, sel_d_next;

  // A rate change or a halt spoils the period in flight, so it is not judged
  always_comb begin
    sel_d_next = reload_reg[SWD_PSEL_BIT];
    gap_next = tick ? '0 : gap_reg + 1'b1;
    gap_ok_next = gap_ok_reg;
    if (halt || (sel_d_reg != reload_reg[SWD_PSEL_BIT])) begin
      gap_ok_next = 1'b0;
    end else if (tick) begin
      gap_ok_next = 1'b1;
    end
  end

  // Helper state only registers its next values
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gap_reg <= '0;
      gap_ok_reg <= 1'b0;
      sel_d_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      gap_ok_reg <= gap_ok_next;
      sel_d_reg <= sel_d_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  tick_rate_a:
    assert property (tick && gap_ok_reg && !halt && sel_d_reg == reload_reg[SWD_PSEL_BIT]
      |-> gap_reg == (reload_reg[SWD_PSEL_BIT] ? SWD_SLOW_DIV - 1 : SWD_FAST_DIV - 1))
    else $error("tick spacing wrong for selected rate");

  overflow_reset_a:
    assert property (running_reg && tick && !halt && count_reg == SWD_CNT_TOP && !reload_do
      |=> wdt_reset_out && !watchdog_running && count_value == SWD_CNT_RST)
    else $error("overflow did not raise internal reset");

  reset_cause_a:
    assert property (wdt_reset_out |-> watchdog_reset_status_flag ##1 watchdog_reset_status_flag)
    else $error("reset cause flag not held after watchdog reset");

  reset_only_ovf_a:
    assert property ($rose(wdt_reset_out) |-> $past(count_reg) == SWD_CNT_TOP && $past(running_reg))
    else $error("internal reset without overflow");

  no_stop_a:
    assert property (running_reg && !overflow |=> running_reg)
    else $error("running watchdog stopped");

  start_a:
    assert property (sw_req.valid && sw_req.watchdog_start_bit && !overflow |=> watchdog_running)
    else $error("start bit did not start the timer");

  refresh_load_a:
    assert property (sw_req.valid && pending_reg && sw_req.watchdog_start_bit && running_reg
      |=> count_value == {$past(reload_reg[SWD_REL_W-1:0]), SWD_LOW_ZERO})
    else $error("refresh did not load upper bits");

  min_timeout_a:
    assert property (reload_do && reload_reg[SWD_REL_W-1:0] == SWD_REL_MAX
      |=> SWD_CNT_TOP - count_value == 15'(SWD_MIN_TIMEOUT_TICKS - 1))
    else $error("shortest time-out count wrong");

  broken_seq_a:
    assert property (sw_req.valid && pending_reg && !sw_req.watchdog_start_bit && !overflow
      && !(running_reg && tick && !halt) |=> count_value == $past(count_reg))
    else $error("counter touched by incomplete refresh");

  frozen_a:
    assert property (halt && !reload_do |=> count_value == $past(count_reg) && !wdt_reset_out)
    else $error("counter moved while halted");

  pulse_once_a:
    assert property (wdt_reset_out |=> !wdt_reset_out)
    else $error("internal reset pulse longer than one cycle");

  flag_sticky_a:
    assert property (watchdog_reset_status_flag |=> watchdog_reset_status_flag)
    else $error("reset cause flag dropped without external reset");

  count_step_a:
    assert property (running_reg && tick && !halt && !reload_do && count_reg != SWD_CNT_TOP
      |=> count_value == $past(count_reg) + 1'b1)
    else $error("counter did not step on tick");

  idle_count_a:
    assert property (!running_reg |=> count_value == $past(count_reg))
    else $error("counter moved before start");

  reload_wr_a:
    assert property (sw_req.valid && sw_req.reload_wr
      |=> watchdog_reload_register == $past(sw_req.reload_data))
    else $error("reload register write lost");

  // Main scenarios worth seeing at least once
  cover_overflow_c: cover property (wdt_reset_out);
  cover_refresh_c: cover property (reload_do);
  cover_slow_c: cover property (tick && reload_reg[SWD_PSEL_BIT] && gap_ok_reg);
  cover_freeze_c: cover property ((halt && running_reg) [*4]);
  cover_broken_c: cover property (sw_req.valid && pending_reg && !sw_req.watchdog_start_bit);

endmodule

// ==== src/swd_pkg.sv ====
package swd_pkg;

  // Counter geometry
  localparam int SWD_CNT_W = 15;
  localparam int SWD_REL_W = 7;
  localparam int SWD_LOW_W = 8;
  localparam int SWD_REG_W = 8;
  localparam int SWD_PSEL_BIT = 7;

  // Count rates as oscillator divisors
  localparam int SWD_FAST_DIV = 12;
  localparam int SWD_SLOW_FACTOR = 16;
  localparam int SWD_SLOW_DIV = SWD_FAST_DIV * SWD_SLOW_FACTOR;

  // Reset and boundary values
  localparam logic [SWD_CNT_W-1:0] SWD_CNT_RST = 15'h0000;
  localparam logic [SWD_CNT_W-1:0] SWD_CNT_TOP = 15'h7FFF;
  localparam logic [SWD_REG_W-1:0] SWD_RELOAD_RST = 8'h00;
  localparam logic [SWD_LOW_W-1:0] SWD_LOW_ZERO = 8'h00;
  localparam logic [SWD_REL_W-1:0] SWD_REL_MAX = 7'h7F;

  // Shortest time-out at the reference oscillator
  localparam int SWD_MIN_TIMEOUT_US = 256;
  localparam int SWD_REF_OSC_MHZ = 12;
  localparam int SWD_MIN_TIMEOUT_TICKS = SWD_MIN_TIMEOUT_US * SWD_REF_OSC_MHZ / SWD_FAST_DIV;

  // One software instruction touching the watchdog bits
  typedef struct packed {
    logic valid;
    logic watchdog_refresh_bit;
    logic watchdog_start_bit;
    logic reload_wr;
    logic [SWD_REG_W-1:0] reload_data;
  } swd_sw_req_t;

endpackage

// ==== src/swd_prescaler.sv ====
`timescale 1ns/1ps

// Oscillator divider: fast tick every FAST_DIV cycles, slow one every FAST_DIV*SLOW_FACTOR
module swd_prescaler
  import swd_pkg::*;
#(
  parameter int FAST_DIV = SWD_FAST_DIV,
  parameter int SLOW_FACTOR = SWD_SLOW_FACTOR
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic halt,
  input wire logic slow_sel,
  output logic tick
);

  localparam int AW = $clog2(FAST_DIV);
  localparam int BW = $clog2(SLOW_FACTOR);
  localparam logic [AW-1:0] A_LAST = AW'(FAST_DIV - 1);
  localparam logic [BW-1:0] B_LAST = BW'(SLOW_FACTOR - 1);
  localparam logic [AW-1:0] A_ZERO = '0;
  localparam logic [BW-1:0] B_ZERO = '0;

  logic [AW-1:0] a_reg, a_next;
  logic [BW-1:0] b_reg, b_next;
  logic tick_reg, tick_next;
  logic a_wrap;

  // Both stages stand still while halted, so no partial period is lost
  always_comb begin
    a_next = a_reg;
    b_next = b_reg;
    tick_next = 1'b0;
    a_wrap = (a_reg == A_LAST);
    if (!halt) begin
      a_next = a_wrap ? A_ZERO : a_reg + 1'b1;
      if (a_wrap) begin
        b_next = (b_reg == B_LAST) ? B_ZERO : b_reg + 1'b1;
        tick_next = slow_sel ? (b_reg == B_LAST) : 1'b1;
      end
    end else begin
      // A tick raised just as the halt begins waits for the release, not lost
      tick_next = tick_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      a_reg <= A_ZERO;
      b_reg <= B_ZERO;
      tick_reg <= 1'b0;
    end else begin
      a_reg <= a_next;
      b_reg <= b_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
  import swd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  swd_sw_req_t sw_req = '0;
  logic idle_mode = 1'b0;
  logic power_down_mode = 1'b0;
  logic wdt_reset_out;
  logic watchdog_reset_status_flag;
  logic watchdog_running;
  logic [SWD_REG_W-1:0] watchdog_reload_register;
  logic [SWD_CNT_W-1:0] count_value;
  logic [SWD_CNT_W-1:0] mark;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  // Rows: reload value, counter expected right after a refresh
  logic [22:0] rows [4] = '{{8'h00, 15'h0000}, {8'h7F, 15'h7F00}, {8'h80, 15'h0000},
                            {8'h55, 15'h5500}};

  swd_watchdog dut_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sw_req(sw_req),
    .idle_mode(idle_mode),
    .power_down_mode(power_down_mode),
    .wdt_reset_out(wdt_reset_out),
    .watchdog_reset_status_flag(watchdog_reset_status_flag),
    .watchdog_running(watchdog_running),
    .watchdog_reload_register(watchdog_reload_register),
    .count_value(count_value)
  );

  // 40 MHz system clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the roughly 5600 cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [SWD_CNT_W-1:0] got, input logic [SWD_CNT_W-1:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One instruction: valid for a single cycle, driven at falling edges
  task automatic instr(input logic rf, input logic st, input logic wr, input logic [7:0] d);
    @(negedge clk_sys);
    sw_req <= '{valid: 1'b1, watchdog_refresh_bit: rf, watchdog_start_bit: st,
                reload_wr: wr, reload_data: d};
    @(negedge clk_sys);
    sw_req <= '0;
  endtask

  // Refresh pair; two back-to-back instructions
  task automatic refresh;
    instr(1'b1, 1'b0, 1'b0, 8'h00);
    instr(1'b0, 1'b1, 1'b0, 8'h00);
  endtask

  initial begin
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(watchdog_running, 1'b0, "running after reset");
    chk(watchdog_reset_status_flag, 1'b0, "flag after reset");
    chk(count_value, SWD_CNT_RST, "count after reset");
    instr(1'b0, 1'b1, 1'b0, 8'h00);
    chk(watchdog_running, 1'b1, "start");
    foreach (rows[i]) begin
      instr(1'b0, 1'b0, 1'b1, rows[i][22:15]);
      chk(watchdog_reload_register, rows[i][22:15], "reload readback");
      refresh();
      chk(count_value, rows[i][14:0], "reload value");
    end
    // Rates: exact tick counts over whole prescale periods
    instr(1'b0, 1'b0, 1'b1, 8'h00);
    refresh();
    mark = count_value;
    repeat (120) @(negedge clk_sys);
    chk(count_value - mark, 15'h000A, "fast rate");
    instr(1'b0, 1'b0, 1'b1, 8'h80);
    repeat (200) @(negedge clk_sys);
    mark = count_value;
    repeat (1920) @(negedge clk_sys);
    chk(count_value - mark, 15'h000A, "slow rate");
    // Idle then power-down freeze the counter
    for (int m = 0; m < 2; m++) begin
      mark = count_value;
      idle_mode = (m == 0);
      power_down_mode = (m == 1);
      repeat (100) @(negedge clk_sys);
      chk(count_value, mark, "frozen count");
      idle_mode = 1'b0;
      power_down_mode = 1'b0;
    end
    // Broken pair: other instruction between refresh and start
    instr(1'b0, 1'b0, 1'b1, 8'h00);
    refresh();
    instr(1'b0, 1'b0, 1'b1, 8'h7F);
    instr(1'b1, 1'b0, 1'b0, 8'h00);
    instr(1'b0, 1'b0, 1'b0, 8'h00);
    instr(1'b0, 1'b1, 1'b0, 8'h00);
    chk(count_value[14:8], 7'h00, "broken pair reload");
    chk(watchdog_running, 1'b1, "still running");
    // Overflow from the shortest setting: 256 ticks of 12 clocks
    refresh();
    n = 0;
    while (wdt_reset_out !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    // First tick lands 1 to 12 clocks after the load, the 256th 3060 later
    chk(n >= 3061 && n <= 3072, 1'b1, "time-out length");
    chk({watchdog_reset_status_flag, watchdog_running}, 2'b10, "after overflow");
    chk(count_value, SWD_CNT_RST, "count after overflow");
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    chk(watchdog_reset_status_flag, 1'b0, "external reset cause");
    summarize();
  end
endmodule
